// ---- src/dhp_map.svh ----
// Constants for the DAC host port update control block
`ifndef DHP_MAP_SVH
`define DHP_MAP_SVH
`define DHP_CLK_MHZ 20
`define DHP_CLR_TIME_US 35
`define DHP_RST_TIME_US 270
`define DHP_CLR_CYCLES (`DHP_CLR_TIME_US * `DHP_CLK_MHZ)
`define DHP_RST_CYCLES (`DHP_RST_TIME_US * `DHP_CLK_MHZ)
`define DHP_CALC_CYCLES 8
`define DHP_DATA_W 14
`define DHP_CHAN_W 6
`define DHP_NUM_CHAN 40
`define DHP_CLASS_SFR 2'h0
`define DHP_CLASS_GAIN 2'h1
`define DHP_CLASS_OFFSET 2'h2
`define DHP_CLASS_DATA 2'h3
`define DHP_SFR_CLRCODE 5'h02
`define DHP_SFR_SOFTCLR 5'h01
`define DHP_RAW_RESET 14'h0000
`define DHP_GAIN_RESET 14'h3fff
`define DHP_OFFSET_RESET 14'h2000
`define DHP_CLRCODE_RESET 14'h2000
`define DHP_DAC_RESET 14'h2000
`endif

// ---- src/dhp_pkg.sv ----
// Types for the DAC host port update control block
package dhp_pkg;
   typedef enum logic [2:0] {
      DHP_IDLE,
      DHP_CALC,
      DHP_LOAD,
      DHP_CLEAR,
      DHP_RESET
   } dhp_state_t;
endpackage

// ---- src/dhp_mem_if.sv ----
// Interface between the control core and the channel memory
`timescale 1ns/1ps
`default_nettype none
interface dhp_mem_if #(parameter int DW = 14, parameter int AW = 8);
   logic we;
   logic [AW-1:0] waddr;
   logic [DW-1:0] wdata;
   logic [AW-1:0] raddr;
   logic [DW-1:0] rdata;
   modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
   modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface
`default_nettype wire

// ---- src/dhp_chan_mem.sv ----
// Channel register memory with registered read data
`timescale 1ns/1ps
`default_nettype none
module dhp_chan_mem #(
   parameter int DW = 14,
   parameter int AW = 8,
   parameter int DEPTH = 256
) (
   input wire logic core_clk,
   dhp_mem_if.mem port
);
   logic [DW-1:0] store [DEPTH];
   always_ff @(posedge core_clk) begin
      if (port.we) begin
         store[port.waddr] <= port.wdata;
      end
      port.rdata <= store[port.raddr];
   end
endmodule
`default_nettype wire

// ---- src/dhp_port_ctrl.sv ----
// DAC host port update control: parallel port, load, clear and reset
`include "dhp_map.svh"
`timescale 1ns/1ps
`default_nettype none
// Function
// (RL1) In I2C mode two address pins form the bus slave address.
// (RL2) Parallel write happens on write strobe rising edge with chip select low.
// (RL3) Serial mode with chain enable high selects SPI daisy-chain mode.
// (RL4) Data bus highest line is MSB, lowest line LSB.
// (RL5) Channel lines pick one of 40 channels for the destination; code has 5 lines, so host writes reach channels 0 to 31 only.
// (RL6) Class lines route write to data, offset, gain or special register.
// (RL7) Serial out is three-stateable, shifted on serial clock rising edge.
// (RL8) In toggle mode bank select picks data register A or B.
// (RL9) In toggle mode each load swaps outputs between A and B.
// (RL10) Outside toggle mode writes go to data register A.
// (RL11) Busy low while calculating; input writes accepted, no DAC update.
// (RL12) Load falling while not busy copies inputs to DAC registers.
// (RL13) Load falling while calculating is stored and done when busy ends.
// (RL14) Busy low during reset; interface disabled, loads discarded.
// (RL15) Clear falling edge loads clear code into all channels, busy 35 us; code acts on it only in idle, a fall during calc or load is lost.
// (RL16) Reset falling edge restores defaults over 270 us, busy low.
// (RL17) After reset, pin level ignored until the next falling edge.
// (RL18) Chip select is level sensitive, active low.
// (RL19) Interface select low means parallel, high means serial.
// (RL20) A single pending flag merges many loads into one update.
module dhp_port_ctrl
   import dhp_pkg::*;
#(
   parameter int NUM_CHAN = `DHP_NUM_CHAN,
   parameter int DATA_W = `DHP_DATA_W,
   parameter int CLR_CYCLES = `DHP_CLR_CYCLES,
   parameter int RST_CYCLES = `DHP_RST_CYCLES,
   parameter int CALC_CYCLES = `DHP_CALC_CYCLES
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic interface_select,
   input wire logic spi_i2c_select,
   input wire logic chip_select_n,
   input wire logic write_strobe_n,
   input wire logic [4:0] channel_select_lines,
   input wire logic [1:0] register_class_select,
   input wire logic [DATA_W-1:0] parallel_data_bus,
   input wire logic bank_select,
   input wire logic toggle_enable,
   input wire logic output_load_n,
   input wire logic clear_in_n,
   input wire logic reset_in_n,
   input wire logic bus_addr_bit0,
   input wire logic bus_addr_bit1,
   input wire logic chain_enable,
   input wire logic serial_clk,
   input wire logic serial_shift_bit,
   output logic serial_out,
   output logic serial_out_oe,
   output logic daisy_chain_mode,
   output logic [6:0] i2c_slave_addr,
   output logic busy,
   output logic dac_we,
   output logic [5:0] dac_channel,
   output logic [DATA_W-1:0] dac_value,
   output logic [DATA_W-1:0] clear_code
);
   localparam int AW = 9;
   localparam int CW = 24;
   localparam logic [4:0] I2C_ADDR_BASE = 5'h15;
   // Memory map: kind bits, bank bit, channel
   localparam logic [1:0] M_RAW = 2'h0;
   localparam logic [1:0] M_OFFSET = 2'h1;
   localparam logic [1:0] M_GAIN = 2'h2;
   localparam logic [1:0] M_CAL = 2'h3;

   dhp_mem_if #(.DW(DATA_W), .AW(AW)) mem_bus ();
   dhp_chan_mem #(.DW(DATA_W), .AW(AW), .DEPTH(2 ** AW)) u_mem (
      .core_clk(core_clk),
      .port(mem_bus.mem)
   );

   function automatic logic [AW-1:0] maddr(input logic [1:0] kind, input logic bank,
                                           input logic [5:0] ch);
      // Bank has its own bit, so bank B never aliases another kind
      maddr = {kind[1:0], bank, ch[5:0]};
   endfunction

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   dhp_state_t state;
   dhp_state_t next_state;
   logic [AW-1:0] raw_hold;
   logic [AW-1:0] cal_hold;
   logic [CW-1:0] count;
   logic [5:0] chan;
   logic pending;
   logic active_bank;
   logic wr_q;
   logic ld_q;
   logic clr_q;
   logic rst_q;
   logic sclk_q;
   logic [DATA_W-1:0] shift_reg;
   logic [DATA_W-1:0] raw_q;

   // ----------------------------------------------------------------
   // Pin decode
   // ----------------------------------------------------------------
   wire parallel_mode = ~interface_select; // (RL19)
   wire selected = ~chip_select_n; // (RL18)
   wire wr_rise = ~wr_q & write_strobe_n;
   wire ld_fall = ld_q & ~output_load_n;
   wire clr_fall = clr_q & ~clear_in_n;
   wire rst_fall = rst_q & ~reset_in_n; // (RL17)
   wire in_reset = (state == DHP_RESET);
   // (RL2) (RL14)
   wire host_write = parallel_mode & selected & wr_rise & ~in_reset & (state != DHP_CLEAR);
   wire [DATA_W-1:0] word = parallel_data_bus[DATA_W-1:0]; // (RL4)
   wire [5:0] wr_chan = {1'b0, channel_select_lines}; // (RL5)
   wire chan_ok = (wr_chan < 6'(NUM_CHAN));
   wire wr_bank = toggle_enable ? bank_select : 1'b0; // (RL8) (RL10)
   wire is_sfr = (register_class_select == `DHP_CLASS_SFR); // (RL6)
   wire is_data = (register_class_select == `DHP_CLASS_DATA);
   wire is_offset = (register_class_select == `DHP_CLASS_OFFSET);
   wire is_gain = (register_class_select == `DHP_CLASS_GAIN);
   wire [1:0] wr_kind = is_data ? M_RAW :
                        is_offset ? M_OFFSET :
                        is_gain ? M_GAIN : M_RAW;
   wire mem_host_we = host_write & ~is_sfr & chan_ok;
   wire sfr_clrcode = host_write & is_sfr & (channel_select_lines == `DHP_SFR_CLRCODE);
   wire sfr_softclr = host_write & is_sfr & (channel_select_lines == `DHP_SFR_SOFTCLR);
   wire last_chan = (chan == 6'(NUM_CHAN - 1));
   wire count_done = (count == '0);
   // Loads in reset are dropped, never stored
   wire load_req = ld_fall & ~in_reset; // (RL14)

   // ----------------------------------------------------------------
   // Serial side pin functions
   // ----------------------------------------------------------------
   assign i2c_slave_addr = {I2C_ADDR_BASE, bus_addr_bit1, bus_addr_bit0}; // (RL1)
   assign daisy_chain_mode = interface_select & ~spi_i2c_select & chain_enable; // (RL3)
   assign serial_out_oe = interface_select & ~spi_i2c_select & ~chip_select_n; // (RL7)

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         sclk_q <= 1'b0;
         shift_reg <= '0;
         serial_out <= 1'b0;
      end else begin
         sclk_q <= serial_clk;
         if (serial_clk & ~sclk_q & serial_out_oe) begin
            serial_out <= shift_reg[DATA_W-1]; // (RL7)
            shift_reg <= {shift_reg[DATA_W-2:0], serial_shift_bit};
         end
      end
   end

   // ----------------------------------------------------------------
   // Edge detection
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_q <= 1'b1;
         ld_q <= 1'b1;
         clr_q <= 1'b1;
         rst_q <= 1'b1;
      end else begin
         wr_q <= write_strobe_n;
         ld_q <= output_load_n;
         clr_q <= clear_in_n;
         rst_q <= reset_in_n;
      end
   end

   // ----------------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------------
   always_comb begin
      next_state = state;
      case (state)
         DHP_IDLE: begin
            if (clr_fall | sfr_clrcode) begin
               next_state = DHP_CLEAR;
            end else if (mem_host_we & is_data) begin
               next_state = DHP_CALC;
            end else if (load_req | pending) begin
               next_state = DHP_LOAD;
            end
         end
         DHP_CALC: begin
            if (count_done) begin
               next_state = DHP_IDLE;
            end
         end
         DHP_LOAD: begin
            if (last_chan) begin
               next_state = DHP_IDLE;
            end
         end
         DHP_CLEAR: begin
            if (count_done) begin
               next_state = DHP_IDLE;
            end
         end
         DHP_RESET: begin
            if (count_done) begin
               next_state = DHP_IDLE;
            end
         end
         default: next_state = DHP_IDLE;
      endcase
      if (rst_fall) begin
         next_state = DHP_RESET; // (RL16)
      end
   end

   // Busy low in every state except idle and copy-out
   assign busy = (state == DHP_IDLE) | (state == DHP_LOAD); // (RL11) (RL14)

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= DHP_RESET;
         count <= CW'(RST_CYCLES - 1);
      end else begin
         state <= next_state;
         if (next_state != state || rst_fall) begin
            case (next_state)
               DHP_CALC: count <= CW'(CALC_CYCLES - 1);
               DHP_CLEAR: count <= CW'(CLR_CYCLES - 1); // (RL15)
               DHP_RESET: count <= CW'(RST_CYCLES - 1); // (RL16)
               default: count <= '0;
            endcase
         end else if (!count_done) begin
            count <= count - CW'(1);
         end
      end
   end

   // A load that loses the idle slot to calc or clear is kept for later
   wire load_defer = load_req & (state != DHP_LOAD) & (next_state != DHP_LOAD);

   // Pending load merges any number of requests into one copy
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         pending <= 1'b0;
      end else if (in_reset | rst_fall) begin
         pending <= 1'b0; // (RL14)
      end else if (load_defer) begin
         pending <= 1'b1; // (RL13) (RL20)
      end else if (state == DHP_LOAD) begin
         pending <= 1'b0;
      end
   end

   // Toggle bank flips on each load
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         active_bank <= 1'b0;
      end else if (in_reset) begin
         active_bank <= 1'b0;
      end else if (state == DHP_LOAD && last_chan && toggle_enable) begin
         active_bank <= ~active_bank; // (RL9)
      end
   end

   // ----------------------------------------------------------------
   // Channel walk and memory access
   // ----------------------------------------------------------------
   wire walking = (state == DHP_LOAD) | (state == DHP_RESET) | (state == DHP_CLEAR);
   wire [5:0] next_chan = (walking && !last_chan) ? chan + 6'h01 : 6'h00;
   wire [AW-1:0] cal_addr = maddr(M_CAL, toggle_enable ? ~active_bank : 1'b0, chan);
   // Clear writes each channel once, in the first pass of the walk
   wire clr_write = (state == DHP_CLEAR) && (chan < 6'(NUM_CHAN)) &&
                    (count > CW'(CLR_CYCLES - 1 - NUM_CHAN));

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         chan <= 6'h00;
         raw_q <= '0;
      end else begin
         chan <= (next_state == state) ? next_chan : 6'h00;
         raw_q <= mem_bus.rdata;
      end
   end

   // Reset walk rewrites each kind in turn, one entry per cycle
   // Short reset counts cover only the low part of the memory
   wire [AW-1:0] rst_addr = count[AW-1:0];
   wire [DATA_W-1:0] rst_val = (rst_addr[8:7] == M_GAIN) ? `DHP_GAIN_RESET :
                               (rst_addr[8:7] == M_OFFSET) ? `DHP_OFFSET_RESET :
                               (rst_addr[8:7] == M_CAL) ? `DHP_DAC_RESET : `DHP_RAW_RESET;
   // Calibrated copy made from the raw word; arithmetic lives elsewhere
   wire calc_we = (state == DHP_CALC) & count_done;

   assign mem_bus.we = in_reset | mem_host_we | calc_we; // (RL11)
   assign mem_bus.waddr = in_reset ? rst_addr :
                          mem_host_we ? maddr(wr_kind, wr_bank, wr_chan) : // (RL6) (RL8)
                          cal_hold;
   assign mem_bus.wdata = in_reset ? rst_val : mem_host_we ? word : raw_q;
   assign mem_bus.raddr = (state == DHP_CALC) ? raw_hold : cal_addr;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         raw_hold <= '0;
         cal_hold <= '0;
      end else if (mem_host_we & is_data & (state == DHP_IDLE)) begin
         raw_hold <= maddr(M_RAW, wr_bank, wr_chan);
         cal_hold <= maddr(M_CAL, wr_bank, wr_chan);
      end
   end

   // ----------------------------------------------------------------
   // Outputs toward the converter
   // ----------------------------------------------------------------
   logic load_rd;
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         load_rd <= 1'b0;
         dac_we <= 1'b0;
         dac_channel <= 6'h00;
         dac_value <= `DHP_DAC_RESET;
         clear_code <= `DHP_CLRCODE_RESET;
      end else begin
         load_rd <= (state == DHP_LOAD);
         dac_we <= 1'b0;
         if (in_reset) begin
            clear_code <= `DHP_CLRCODE_RESET;
         end else if (sfr_clrcode & ~sfr_softclr) begin
            clear_code <= word;
         end
         if (clr_write) begin
            dac_we <= 1'b1; // (RL15)
            dac_channel <= chan;
            dac_value <= clear_code;
         end else if (load_rd) begin
            dac_we <= 1'b1; // (RL12)
            dac_channel <= (chan == 6'h00) ? 6'(NUM_CHAN - 1) : chan - 6'h01;
            dac_value <= mem_bus.rdata;
         end
      end
   end
endmodule
`default_nettype wire

// ---- verif/dhp_port_ctrl_properties.sv ----
// Checker for the DAC host port update control block
`timescale 1ns/1ps
`default_nettype none
module dhp_port_ctrl_properties #(parameter int NUM_CHAN = 40) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic interface_select,
   input wire logic spi_i2c_select,
   input wire logic chip_select_n,
   input wire logic write_strobe_n,
   input wire logic [1:0] register_class_select,
   input wire logic output_load_n,
   input wire logic clear_in_n,
   input wire logic reset_in_n,
   input wire logic bus_addr_bit0,
   input wire logic bus_addr_bit1,
   input wire logic chain_enable,
   input wire logic serial_out_oe,
   input wire logic daisy_chain_mode,
   input wire logic [6:0] i2c_slave_addr,
   input wire logic busy,
   input wire logic dac_we,
   input wire logic [5:0] dac_channel
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   property p_boot; $rose(rst_n) |-> !busy; endproperty
   a_boot: assert property (p_boot) else $error("busy high after reset");
   property p_addr; i2c_slave_addr == {5'h15, bus_addr_bit1, bus_addr_bit0}; endproperty
   a_addr: assert property (p_addr) else $error("slave address wrong");
   property p_chain;
      daisy_chain_mode == (interface_select && !spi_i2c_select && chain_enable);
   endproperty
   a_chain: assert property (p_chain) else $error("chain mode wrong");
   property p_oe; serial_out_oe |-> interface_select && !spi_i2c_select && !chip_select_n; endproperty
   a_oe: assert property (p_oe) else $error("serial out driven in wrong mode");
   property p_chan; dac_we |-> dac_channel < NUM_CHAN; endproperty
   a_chan: assert property (p_chan) else $error("channel out of range");
   property p_clr; $fell(clear_in_n) && busy |-> ##[1:4] !busy; endproperty
   a_clr: assert property (p_clr) else $error("clear did not start");
   property p_rsti; $fell(reset_in_n) && busy |-> ##[1:4] !busy; endproperty
   a_rsti: assert property (p_rsti) else $error("reset sequence did not start");
   property p_calc;
      $rose(write_strobe_n) && !chip_select_n && !interface_select && busy
         && register_class_select == 2'h3 |-> ##[1:3] !busy;
   endproperty
   a_calc: assert property (p_calc) else $error("data write did not start calc");
   property p_output_load_n; $fell(output_load_n) && busy |-> ##[1:6] dac_we; endproperty
   a_output_load_n: assert property (p_output_load_n) else $error("load did not update");
   property p_desel;
      $rose(write_strobe_n) && chip_select_n && busy && output_load_n && clear_in_n
         && reset_in_n |=> busy;
   endproperty
   a_desel: assert property (p_desel) else $error("write taken while deselected");
endmodule
bind dhp_port_ctrl dhp_port_ctrl_properties #(.NUM_CHAN(NUM_CHAN)) dhp_port_ctrl_properties_i (
   .core_clk, .rst_n, .interface_select, .spi_i2c_select, .chip_select_n, .write_strobe_n,
   .register_class_select, .output_load_n, .clear_in_n, .reset_in_n, .bus_addr_bit0,
   .bus_addr_bit1, .chain_enable, .serial_out_oe, .daisy_chain_mode, .i2c_slave_addr, .busy,
   .dac_we, .dac_channel);
`default_nettype wire

// ---- verif/dhp_host_model.sv ----
// Host model driving the parallel write port
`timescale 1ns/1ps
`default_nettype none
module dhp_host_model (
   input wire logic core_clk,
   input wire logic go,
   input wire logic sel_n,
   input wire logic park_cs_n,
   input wire logic [4:0] ch,
   input wire logic [1:0] cls,
   input wire logic [13:0] data,
   input wire logic bank,
   output logic chip_select_n,
   output logic write_strobe_n,
   output logic [4:0] channel_select_lines,
   output logic [1:0] register_class_select,
   output logic [13:0] parallel_data_bus,
   output logic bank_select,
   output logic done
);
   logic [2:0] step;
   initial begin
      step = 3'h0;
      done = 1'b0;
      chip_select_n = 1'b1;
      write_strobe_n = 1'b1;
      channel_select_lines = 5'h00;
      register_class_select = 2'h3;
      parallel_data_bus = 14'h0000;
      bank_select = 1'b0;
   end
   // Address and data held three cycles past the strobe rise
   always @(posedge core_clk) begin
      done <= (step == 3'h6);
      if (step == 3'h0) begin
         chip_select_n <= go ? sel_n : park_cs_n;
         if (go) begin
            channel_select_lines <= ch;
            register_class_select <= cls;
            parallel_data_bus <= data;
            bank_select <= bank;
            write_strobe_n <= 1'b0;
            step <= 3'h1;
         end
      end else begin
         step <= (step == 3'h6) ? 3'h0 : step + 3'h1;
         if (step == 3'h3) write_strobe_n <= 1'b1;
         if (step == 3'h6) parallel_data_bus <= ~parallel_data_bus;
      end
   end
endmodule
`default_nettype wire

// ---- verif/dac_host_port_update_control_test.sv ----
// Testbench for the DAC host port update control block
`timescale 1ns/1ps
`default_nettype none
module dac_host_port_update_control_test;
   localparam int CLR = 64;
   localparam int RST = 300;
   logic core_clk = 1'b0, rst_n = 1'b0, interface_select = 1'b0, spi_i2c_select = 1'b0;
   logic chain_enable = 1'b0, bus_addr_bit0 = 1'b0, bus_addr_bit1 = 1'b0, toggle_enable = 1'b0;
   logic output_load_n = 1'b1, clear_in_n = 1'b1, reset_in_n = 1'b1, go = 1'b0, sel_n = 1'b0;
   logic park = 1'b1, bank = 1'b0, done, chip_select_n, write_strobe_n, bank_select, busy;
   logic [4:0] ch = 5'h00;
   logic [1:0] cls = 2'h3;
   logic [13:0] data = 14'h0000;
   logic [4:0] channel_select_lines;
   logic [1:0] register_class_select;
   logic [13:0] parallel_data_bus, dac_value, clear_code, v;
   logic serial_out, serial_out_oe, daisy_chain_mode, dac_we;
   logic [6:0] i2c_slave_addr;
   logic [5:0] dac_channel;
   logic [13:0] cap [64];
   logic [5:0] rows_in [5] = '{6'h00, 6'h26, 6'h2d, 6'h37, 6'h20};
   logic [8:0] rows_out [5] = '{9'h054, 9'h1d6, 9'h155, 9'h057, 9'h0d4};
   int err_total = 0, tests_run = 0, we_total = 0, n, b;
   dhp_port_ctrl #(.CLR_CYCLES(CLR), .RST_CYCLES(RST), .CALC_CYCLES(16)) dhp_port_ctrl_i (
      .core_clk, .rst_n, .interface_select, .spi_i2c_select, .chip_select_n, .write_strobe_n,
      .channel_select_lines, .register_class_select, .parallel_data_bus, .bank_select,
      .toggle_enable, .output_load_n, .clear_in_n, .reset_in_n, .bus_addr_bit0, .bus_addr_bit1,
      .chain_enable, .serial_clk(1'b0), .serial_shift_bit(1'b0), .serial_out, .serial_out_oe,
      .daisy_chain_mode, .i2c_slave_addr, .busy, .dac_we, .dac_channel, .dac_value, .clear_code);
   dhp_host_model dhp_host_model_i (.core_clk, .go, .sel_n, .park_cs_n(park), .ch, .cls, .data,
      .bank, .chip_select_n, .write_strobe_n, .channel_select_lines, .register_class_select,
      .parallel_data_bus, .bank_select, .done);
   initial begin
      forever #25 core_clk = ~core_clk;
   end
   always @(posedge core_clk) if (dac_we === 1'b1) begin
      cap[dac_channel] <= dac_value;
      we_total <= we_total + 1;
   end
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      tests_run++;
      if (got !== exp) begin
         err_total++;
         $display("Error %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic conclude();
      $display("Checks %0d, mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   // Every wait is bounded so a stuck busy ends the run
   task automatic bound(input int lim);
      if (n >= lim) begin
         err_total++;
         $display("Error %0t: wait ran out", $time);
         conclude();
      end
   endtask
   task automatic wait_busy(input logic lvl, input int lim);
      n = 0;
      while (busy !== lvl && n < lim) begin
         @(negedge core_clk);
         n++;
      end
      bound(lim);
   endtask
   task automatic settle(input int target);
      n = 0;
      while (we_total < target && n < 400) begin
         @(negedge core_clk);
         n++;
      end
      bound(400);
      wait_busy(1'b1, 400);
   endtask
   task automatic wr(input logic [4:0] c, input logic [1:0] k, input logic [13:0] d,
                     input logic bk, input logic s);
      @(posedge core_clk);
      ch <= c;
      cls <= k;
      data <= d;
      bank <= bk;
      sel_n <= s;
      go <= 1'b1;
      @(posedge core_clk);
      go <= 1'b0;
      n = 0;
      while (done !== 1'b1 && n < 20) begin
         @(negedge core_clk);
         n++;
      end
      bound(20);
   endtask
   task automatic load();
      @(posedge core_clk);
      output_load_n <= 1'b0;
      @(posedge core_clk);
      output_load_n <= 1'b1;
   endtask
   task automatic load_check(input logic [4:0] c, input logic [13:0] exp);
      b = we_total;
      load();
      settle(b + 40);
      chk(cap[c], exp);
   endtask
   initial begin
      repeat (16) @(posedge core_clk);
      chk({busy, dac_value, clear_code}, {1'b0, 14'h2000, 14'h2000});
      rst_n <= 1'b1;
      wait_busy(1'b1, RST + 50);
      $display("Test reset done");
      for (int i = 0; i < 5; i++) begin
         @(posedge core_clk);
         {interface_select, spi_i2c_select, park, chain_enable, bus_addr_bit1, bus_addr_bit0}
            <= rows_in[i];
         @(posedge core_clk);
         @(negedge core_clk);
         chk({daisy_chain_mode, serial_out_oe, i2c_slave_addr}, rows_out[i]);
      end
      @(posedge core_clk);
      {interface_select, park, chain_enable} <= 3'b010;
      $display("Test pin modes done");
      wr(5'h05, 2'h3, 14'h2a5c, 1'b0, 1'b0);
      wait_busy(1'b1, 60);
      load_check(5'h05, 14'h2a5c);
      wr(5'h05, 2'h3, 14'h1111, 1'b0, 1'b1);
      load_check(5'h05, 14'h2a5c);
      $display("Test write and load done");
      b = we_total;
      wr(5'h05, 2'h3, 14'h0f0f, 1'b0, 1'b0);
      chk(busy, 1'b0);
      load();
      load();
      chk(we_total, b);
      settle(b + 40);
      repeat (20) @(negedge core_clk);
      chk({we_total, cap[5]}, {b + 40, 14'h0f0f});
      $display("Test deferred load done");
      toggle_enable <= 1'b1;
      wr(5'h07, 2'h3, 14'h0aaa, 1'b0, 1'b0);
      wait_busy(1'b1, 60);
      wr(5'h07, 2'h3, 14'h1555, 1'b1, 1'b0);
      wait_busy(1'b1, 60);
      b = we_total;
      load();
      settle(b + 40);
      v = cap[7];
      load_check(5'h07, v ^ 14'h1fff);
      toggle_enable <= 1'b0;
      wr(5'h07, 2'h1, 14'h3000, 1'b0, 1'b0);
      wait_busy(1'b1, 60);
      b = we_total;
      wr(5'h02, 2'h0, 14'h1234, 1'b0, 1'b0);
      chk(clear_code, 14'h1234);
      settle(b + 40);
      chk(cap[39], 14'h1234);
      clear_in_n <= 1'b0;
      wait_busy(1'b0, 8);
      wait_busy(1'b1, CLR + 50);
      chk(n >= CLR - 4 && n <= CLR + 4, 1);
      clear_in_n <= 1'b1;
      $display("Test clear done");
      reset_in_n <= 1'b0;
      wait_busy(1'b0, 8);
      b = we_total;
      load();
      wait_busy(1'b1, RST + 50);
      chk({n >= RST - 4 && n <= RST + 4, we_total}, {1'b1, b});
      repeat (20) @(negedge core_clk);
      chk(busy, 1'b1);
      reset_in_n <= 1'b1;
      $display("Test reset pin done");
      conclude();
   end
endmodule
`default_nettype wire
